// ### hdl/scmc_clock_mode_ctrl.sv
// Operation
// [R01] two-stage prescaler drives 21-stage divider, main clock and machine cycle counters
// [R02] prescaler and divider clear on reset, STOP entry and STOP release
// [R03] stage seven input chosen from mode, main clock select and source select
// [R04] slow modes ignore source select; slow clock feeds stage seven
// [R05] warm-up after STOP from fast mode feeds stage seven from stage six
// [R06] software never sets source select while in single-clock mode
// [R07] software sets source select only after slow oscillator is stable
// [R08] machine cycle is four states, one main clock each
// [R09] instructions take one to ten whole machine cycles
// [R10] single-clock mode runs fast oscillator only; slow pins are ports
// [R11] reset leaves device in single-clock normal mode
// [R12] idle request in single-clock halts core and watchdog, peripherals run
// [R13] any interrupt ends single-clock idle; serviced first when master enable set
// [R14] master enable clear: resume at next instruction, no interrupt taken
// [R15] timing halt stops core and all peripheral clocks except base timer
// [R16] base timer source falling edge ends timing halt, back to normal
// [R17] halt ignores timer enable; timer irq needs master, irq and timer enables
// [R18] halt entered with timer enabled sets timer interrupt latch on return
// [R19] dual-clock runs both oscillators; main clock fast or slow per mode
// [R20] software enables slow oscillator early to reach dual-clock mode
// [R21] dual fast run: core on fast clock, peripherals on either clock
// [R22] main clock select moves between dual fast and dual slow run
// [R23] fast enable clear in dual slow gives slow-only; stages 1-6 stop
// [R24] wake requests arriving while core clock is gated are latched; code holds only a request met on the idle entry cycle
`timescale 1ns/1ps
`default_nettype none
module scmc_clock_mode_ctrl
  import scmc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic fast_clock_tick,
  input wire logic slow_clock_tick,
  input wire logic idle_req,
  input wire logic timing_gen_halt,
  input wire logic stop_req,
  input wire logic stop_release,
  input wire logic main_clock_select,
  input wire logic fast_osc_enable,
  input wire logic slow_osc_enable,
  input wire logic stage_seven_source_select,
  input wire logic irq_req,
  input wire logic interrupt_master_enable,
  input wire logic base_timer_enable,
  input wire logic base_timer_irq_enable,
  input wire logic base_timer_src,
  input wire logic base_timer_irq_ack,
  input wire logic [3:0] instr_cycles,
  output scmc_mode_t mode,
  output logic fast_osc_run,
  output logic slow_osc_run,
  output logic slow_pins_as_port,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic base_timer_clk_en,
  output logic [1:0] mc_state,
  output logic instr_done,
  output logic wake_take_irq,
  output logic wake_resume_next,
  output logic base_timer_interrupt,
  output logic base_timer_irq_service,
  output logic divider_pulse_out,
  output logic [DIV_STAGES-1:0] div_value
);

  scmc_mode_t mode_ff, nxt_mode;
  scmc_mode_t stop_ret_ff, nxt_stop_ret;
  logic stop_from_fast_ff, nxt_stop_from_fast;
  logic wake_pend_ff, nxt_wake_pend;
  logic bt_armed_ff, nxt_bt_armed;
  logic bt_src_ff, nxt_bt_src;
  logic bt_latch_ff, nxt_bt_latch;
  logic take_irq_ff, nxt_take_irq;
  logic resume_ff, nxt_resume;
  logic [1:0] mc_state_ff, nxt_mc_state;
  logic [3:0] instr_cnt_ff, nxt_instr_cnt;
  logic [3:0] instr_len_ff, nxt_instr_len;
  logic instr_done_ff, nxt_instr_done;
  logic dvo_ff, nxt_dvo;

  logic is_slow, is_fast, core_runs, wake_idle, halt_idle;
  logic wake_now, bt_fall, warm_done, div_clear, idle_entry;
  logic main_tick, pre_tick, low_run, s7_from_six, s7_ext_tick;
  logic stage6_carry;
  logic [3:0] len_clamped;

  // mode classes
  always_comb begin
    is_slow = (mode_ff == MODE_DUAL_SLOW) || (mode_ff == MODE_SLOW_ONLY) ||
              (mode_ff == MODE_SLEEP_TIMER) || (mode_ff == MODE_SLEEP_SLOW) ||
              (mode_ff == MODE_SLEEP_DUAL);
    is_fast = (mode_ff == MODE_SINGLE_RUN) || (mode_ff == MODE_SINGLE_IDLE) ||
              (mode_ff == MODE_TIMER_IDLE) || (mode_ff == MODE_DUAL_FAST) ||
              (mode_ff == MODE_DUAL_IDLE);
    core_runs = (mode_ff == MODE_SINGLE_RUN) || (mode_ff == MODE_DUAL_FAST) ||
                (mode_ff == MODE_DUAL_SLOW) || (mode_ff == MODE_SLOW_ONLY);
    wake_idle = (mode_ff == MODE_SINGLE_IDLE) || (mode_ff == MODE_DUAL_IDLE) ||
                (mode_ff == MODE_SLEEP_SLOW) || (mode_ff == MODE_SLEEP_DUAL);
    halt_idle = (mode_ff == MODE_TIMER_IDLE) || (mode_ff == MODE_SLEEP_TIMER);
  end

  // wake request seen now or held from the idle entry cycle
  assign wake_now = irq_req || wake_pend_ff; // [R13] [R24]
  // falling edge of the base timer source, sampled on clk
  assign bt_fall = bt_src_ff && !base_timer_src; // [R16]
  assign warm_done = div_value[WARMUP_TAP];

  // mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    nxt_stop_ret = stop_ret_ff;
    nxt_stop_from_fast = stop_from_fast_ff;
    unique case (mode_ff)
      MODE_SINGLE_RUN: begin
        if (stop_req) begin
          nxt_mode = MODE_STOP;
        end else if (timing_gen_halt) begin
          nxt_mode = MODE_TIMER_IDLE; // [R15] [R17]
        end else if (idle_req) begin
          nxt_mode = MODE_SINGLE_IDLE; // [R12]
        end else if (slow_osc_enable) begin
          nxt_mode = MODE_DUAL_FAST; // [R19] [R20]
        end
      end
      MODE_SINGLE_IDLE: begin
        if (wake_now) begin
          nxt_mode = MODE_SINGLE_RUN; // [R13]
        end
      end
      MODE_TIMER_IDLE: begin
        if (bt_fall) begin
          nxt_mode = MODE_SINGLE_RUN; // [R16]
        end
      end
      MODE_DUAL_FAST: begin
        if (stop_req) begin
          nxt_mode = MODE_STOP;
        end else if (main_clock_select) begin
          nxt_mode = MODE_DUAL_SLOW; // [R22]
        end else if (idle_req) begin
          nxt_mode = MODE_DUAL_IDLE;
        end else if (!slow_osc_enable) begin
          nxt_mode = MODE_SINGLE_RUN;
        end
      end
      MODE_DUAL_IDLE: begin
        if (wake_now) begin
          nxt_mode = MODE_DUAL_FAST;
        end
      end
      MODE_DUAL_SLOW: begin
        if (stop_req) begin
          nxt_mode = MODE_STOP;
        end else if (!main_clock_select) begin
          nxt_mode = MODE_DUAL_FAST; // [R22]
        end else if (!fast_osc_enable) begin
          nxt_mode = MODE_SLOW_ONLY; // [R23]
        end else if (idle_req) begin
          nxt_mode = MODE_SLEEP_DUAL;
        end
      end
      MODE_SLOW_ONLY: begin
        if (stop_req) begin
          nxt_mode = MODE_STOP;
        end else if (fast_osc_enable) begin
          nxt_mode = MODE_DUAL_SLOW;
        end else if (timing_gen_halt) begin
          nxt_mode = MODE_SLEEP_TIMER;
        end else if (idle_req) begin
          nxt_mode = MODE_SLEEP_SLOW;
        end
      end
      MODE_SLEEP_TIMER: begin
        if (bt_fall) begin
          nxt_mode = MODE_SLOW_ONLY;
        end
      end
      MODE_SLEEP_SLOW: begin
        if (wake_now) begin
          nxt_mode = MODE_SLOW_ONLY;
        end
      end
      MODE_SLEEP_DUAL: begin
        if (wake_now) begin
          nxt_mode = MODE_DUAL_SLOW;
        end
      end
      MODE_STOP: begin
        if (stop_release) begin
          nxt_mode = MODE_WARMUP;
        end
      end
      MODE_WARMUP: begin
        if (warm_done) begin
          nxt_mode = stop_ret_ff;
        end
      end
      default: begin
        nxt_mode = MODE_RST;
      end
    endcase
    // remember where stop came from, for warm-up feed and return
    if (core_runs && stop_req) begin
      nxt_stop_ret = mode_ff;
      nxt_stop_from_fast = is_fast; // [R05]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_ff <= MODE_RST; // [R11]
      stop_ret_ff <= MODE_RST;
      stop_from_fast_ff <= 1'b1;
    end else begin
      mode_ff <= nxt_mode;
      stop_ret_ff <= nxt_stop_ret;
      stop_from_fast_ff <= nxt_stop_from_fast;
    end
  end

  // clock feeds for the divider; stop kills all oscillators
  always_comb begin
    div_clear = ((mode_ff != MODE_STOP) && (nxt_mode == MODE_STOP)) ||
                ((mode_ff == MODE_STOP) && stop_release); // [R02]
    pre_tick = (mode_ff != MODE_STOP) && fast_clock_tick && fast_osc_run; // [R01]
    low_run = (mode_ff != MODE_SLOW_ONLY) && (mode_ff != MODE_SLEEP_SLOW) &&
              (mode_ff != MODE_SLEEP_TIMER); // [R23]
    s7_ext_tick = (mode_ff != MODE_STOP) && slow_clock_tick;
    if (is_slow) begin
      s7_from_six = 1'b0; // [R04]
    end else if ((mode_ff == MODE_WARMUP) && stop_from_fast_ff) begin
      s7_from_six = 1'b1; // [R05]
    end else if (mode_ff == MODE_WARMUP) begin
      s7_from_six = 1'b0;
    end else begin
      s7_from_six = !stage_seven_source_select; // [R03]
    end
  end

  scmc_divider u_divider (
    .clk(clk),
    .nrst(nrst),
    .clear(div_clear),
    .pre_tick(pre_tick),
    .low_run(low_run),
    .stage7_from_six(s7_from_six),
    .stage7_ext_tick(s7_ext_tick),
    .div_value(div_value),
    .stage6_carry(stage6_carry)
  );

  // main clock: fast in fast modes, slow in slow modes, none in stop
  always_comb begin
    main_tick = is_fast ? fast_clock_tick : (is_slow ? slow_clock_tick : 1'b0); // [R19]
    core_clk_en = main_tick && core_runs; // [R12] [R21]
    periph_clk_en = main_tick && !halt_idle; // [R15]
    base_timer_clk_en = main_tick;
    fast_osc_run = (mode_ff != MODE_STOP) && (mode_ff != MODE_SLOW_ONLY) &&
                   (mode_ff != MODE_SLEEP_SLOW) && (mode_ff != MODE_SLEEP_TIMER);
    slow_osc_run = (mode_ff != MODE_STOP) && (mode_ff != MODE_SINGLE_RUN) &&
                   (mode_ff != MODE_SINGLE_IDLE) && (mode_ff != MODE_TIMER_IDLE);
    slow_pins_as_port = !slow_osc_run && (mode_ff != MODE_STOP); // [R10]
  end

  // machine cycle states and instruction length count
  always_comb begin
    len_clamped = instr_cycles;
    if (instr_cycles < INSTR_MIN_MC) begin
      len_clamped = INSTR_MIN_MC;
    end else if (instr_cycles > INSTR_MAX_MC) begin
      len_clamped = INSTR_MAX_MC; // [R09]
    end
    nxt_mc_state = mc_state_ff;
    nxt_instr_cnt = instr_cnt_ff;
    nxt_instr_len = instr_len_ff;
    nxt_instr_done = 1'b0;
    if (core_clk_en) begin
      nxt_mc_state = mc_state_ff + 1'b1; // [R08]
      if (mc_state_ff == MC_STATE_RST && instr_cnt_ff == INSTR_CNT_RST) begin
        nxt_instr_len = len_clamped;
      end
      if (mc_state_ff == MC_LAST_STATE) begin
        if (instr_cnt_ff + 4'h1 >= instr_len_ff) begin
          nxt_instr_cnt = INSTR_CNT_RST;
          nxt_instr_done = 1'b1; // [R09]
        end else begin
          nxt_instr_cnt = instr_cnt_ff + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mc_state_ff <= MC_STATE_RST;
      instr_cnt_ff <= INSTR_CNT_RST;
      instr_len_ff <= INSTR_MIN_MC;
      instr_done_ff <= 1'b0;
    end else begin
      mc_state_ff <= nxt_mc_state;
      instr_cnt_ff <= nxt_instr_cnt;
      instr_len_ff <= nxt_instr_len;
      instr_done_ff <= nxt_instr_done;
    end
  end

  // wake latch, resume decision and base timer latch; sets win over clears
  always_comb begin
    // a request met at idle entry would be lost; hold it one cycle
    idle_entry = (nxt_mode == MODE_SINGLE_IDLE) || (nxt_mode == MODE_DUAL_IDLE) ||
                 (nxt_mode == MODE_SLEEP_SLOW) || (nxt_mode == MODE_SLEEP_DUAL);
    nxt_wake_pend = !wake_idle && irq_req && idle_entry; // [R24]
    nxt_take_irq = wake_idle && wake_now && interrupt_master_enable; // [R13]
    nxt_resume = wake_idle && wake_now && !interrupt_master_enable; // [R14]
    nxt_bt_armed = bt_armed_ff;
    if (core_runs && timing_gen_halt) begin
      nxt_bt_armed = base_timer_enable; // [R17]
    end
    nxt_bt_src = base_timer_src;
    nxt_bt_latch = bt_latch_ff;
    if (base_timer_irq_ack) begin
      nxt_bt_latch = 1'b0;
    end
    if (halt_idle && bt_fall && bt_armed_ff) begin
      nxt_bt_latch = 1'b1; // [R18]
    end
    nxt_dvo = div_value[DVO_TAP];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wake_pend_ff <= 1'b0;
      take_irq_ff <= 1'b0;
      resume_ff <= 1'b0;
      bt_armed_ff <= 1'b0;
      bt_src_ff <= 1'b0;
      bt_latch_ff <= 1'b0;
      dvo_ff <= 1'b0;
    end else begin
      wake_pend_ff <= nxt_wake_pend;
      take_irq_ff <= nxt_take_irq;
      resume_ff <= nxt_resume;
      bt_armed_ff <= nxt_bt_armed;
      bt_src_ff <= nxt_bt_src;
      bt_latch_ff <= nxt_bt_latch;
      dvo_ff <= nxt_dvo;
    end
  end

  assign mode = mode_ff;
  assign mc_state = mc_state_ff;
  assign instr_done = instr_done_ff;
  assign wake_take_irq = take_irq_ff;
  assign wake_resume_next = resume_ff;
  assign base_timer_interrupt = bt_latch_ff;
  // service needs all three enables; the halt itself ignores them
  assign base_timer_irq_service = bt_latch_ff && interrupt_master_enable &&
                                  base_timer_irq_enable && base_timer_enable; // [R17]
  assign divider_pulse_out = dvo_ff;

  a_reset_mode: assert property (@(posedge clk) // [R11]
    !nrst |=> mode_ff == MODE_SINGLE_RUN)
    else $error("mode not single run after reset");

  a_stop_clears_div: assert property (@(posedge clk) disable iff (!nrst) // [R02]
    (mode_ff == MODE_STOP && stop_release) |=> div_value == '0)
    else $error("divider not cleared on stop release");

  a_s7_select: assert property (@(posedge clk) disable iff (!nrst) // [R03]
    (mode_ff == MODE_DUAL_FAST && stage_seven_source_select && !slow_clock_tick && !stop_req)
      |=> $stable(div_value[DIV_STAGES-1:LOW_STAGES]))
    else $error("stage seven ignores source select");

  a_slow_feed_s7: assert property (@(posedge clk) disable iff (!nrst) // [R04]
    (is_slow && !slow_clock_tick && !stop_req) |=> $stable(div_value[DIV_STAGES-1:LOW_STAGES]))
    else $error("stage seven not fed from slow clock in slow mode");

  a_warm_feed_six: assert property (@(posedge clk) disable iff (!nrst) // [R05]
    (mode_ff == MODE_WARMUP && stop_from_fast_ff) |-> s7_from_six)
    else $error("warm-up from fast mode not fed from stage six");

  a_mc_four_states: assert property (@(posedge clk) disable iff (!nrst) // [R08]
    (core_clk_en && mc_state_ff == MC_LAST_STATE) |=> mc_state_ff == MC_STATE_RST)
    else $error("machine cycle not four states");

  a_idle_core_gated: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    (mode_ff == MODE_SINGLE_IDLE) |-> !core_clk_en && (periph_clk_en == fast_clock_tick))
    else $error("single idle clock gating wrong");

  a_idle_wake: assert property (@(posedge clk) disable iff (!nrst) // [R13]
    (mode_ff == MODE_SINGLE_IDLE && irq_req) |=>
      mode_ff == MODE_SINGLE_RUN && (wake_take_irq == $past(interrupt_master_enable)))
    else $error("single idle did not wake on interrupt");

  a_idle_resume: assert property (@(posedge clk) disable iff (!nrst) // [R14]
    (wake_idle && wake_now && !interrupt_master_enable) |=> wake_resume_next && !wake_take_irq)
    else $error("resume without interrupt missing");

  a_halt_periph_off: assert property (@(posedge clk) disable iff (!nrst) // [R15]
    halt_idle |-> !periph_clk_en && !core_clk_en)
    else $error("peripheral clock running in timing halt");

  a_halt_release: assert property (@(posedge clk) disable iff (!nrst) // [R16] [R18]
    (mode_ff == MODE_TIMER_IDLE && bt_fall) |=> mode_ff == MODE_SINGLE_RUN ##0
      (base_timer_interrupt || !$past(bt_armed_ff)))
    else $error("timing halt release wrong");

  a_slow_low_stop: assert property (@(posedge clk) disable iff (!nrst) // [R23]
    (mode_ff == MODE_SLOW_ONLY && !stop_req) |->
      !stage6_carry ##1 $stable(div_value[LOW_STAGES-1:0]))
    else $error("low stages running in slow-only mode");

endmodule // scmc_clock_mode_ctrl
`default_nettype wire

// ### hdl/scmc_pkg.sv
package scmc_pkg;

  // clock figures
  localparam int CLK_PERIOD_NS = 10;

  // timing generator structure
  localparam int PRESCALE_BITS = 2;
  localparam int DIV_STAGES = 21;
  localparam int LOW_STAGES = 6;
  localparam int HIGH_STAGES = DIV_STAGES - LOW_STAGES;

  // divider tap used as the stop warm-up end, tap for the divider pulse pin
  localparam int WARMUP_TAP = 14;
  localparam int DVO_TAP = 10;

  // machine cycle shape
  localparam int STATES_PER_MC = 4;
  localparam logic [1:0] MC_LAST_STATE = 2'h3;
  localparam logic [3:0] INSTR_MIN_MC = 4'h1;
  localparam logic [3:0] INSTR_MAX_MC = 4'hA;

  // reset values
  localparam logic [PRESCALE_BITS-1:0] PRESCALE_RST = 2'h0;
  localparam logic [LOW_STAGES-1:0] LOW_DIV_RST = 6'h00;
  localparam logic [HIGH_STAGES-1:0] HIGH_DIV_RST = 15'h0000;
  localparam logic [1:0] MC_STATE_RST = 2'h0;
  localparam logic [3:0] INSTR_CNT_RST = 4'h0;

  // operating modes
  typedef enum logic [3:0] {
    MODE_SINGLE_RUN  = 4'h0,
    MODE_SINGLE_IDLE = 4'h1,
    MODE_TIMER_IDLE  = 4'h2,
    MODE_DUAL_FAST   = 4'h3,
    MODE_DUAL_IDLE   = 4'h4,
    MODE_DUAL_SLOW   = 4'h5,
    MODE_SLOW_ONLY   = 4'h6,
    MODE_SLEEP_TIMER = 4'h7,
    MODE_SLEEP_SLOW  = 4'h8,
    MODE_SLEEP_DUAL  = 4'h9,
    MODE_STOP        = 4'hA,
    MODE_WARMUP      = 4'hB
  } scmc_mode_t;

  localparam scmc_mode_t MODE_RST = MODE_SINGLE_RUN;

endpackage

// ### hdl/scmc_divider.sv
`timescale 1ns/1ps
`default_nettype none
// prescaler plus divider, stages 1-6 gated, stage 7 input chosen outside
module scmc_divider
  import scmc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic pre_tick,
  input wire logic low_run,
  input wire logic stage7_from_six,
  input wire logic stage7_ext_tick,
  output logic [DIV_STAGES-1:0] div_value,
  output logic stage6_carry
);

  logic [PRESCALE_BITS-1:0] pre_ff, nxt_pre;
  logic [LOW_STAGES-1:0] low_ff, nxt_low;
  logic [HIGH_STAGES-1:0] high_ff, nxt_high;
  logic pre_out;
  logic stage7_in;

  // prescaler feeds stage 1; stages 1-6 stop when the low chain is gated
  always_comb begin
    pre_out = pre_tick && (pre_ff == '1);
    stage6_carry = pre_out && low_run && (low_ff == '1);
    stage7_in = stage7_from_six ? stage6_carry : stage7_ext_tick;
    nxt_pre = pre_ff;
    nxt_low = low_ff;
    nxt_high = high_ff;
    if (clear) begin
      nxt_pre = PRESCALE_RST;
      nxt_low = LOW_DIV_RST;
      nxt_high = HIGH_DIV_RST;
    end else begin
      if (pre_tick) begin
        nxt_pre = pre_ff + 1'b1;
      end
      if (pre_out && low_run) begin
        nxt_low = low_ff + 1'b1;
      end
      if (stage7_in) begin
        nxt_high = high_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_ff <= PRESCALE_RST;
      low_ff <= LOW_DIV_RST;
      high_ff <= HIGH_DIV_RST;
    end else begin
      pre_ff <= nxt_pre;
      low_ff <= nxt_low;
      high_ff <= nxt_high;
    end
  end

  assign div_value = {high_ff, low_ff};

endmodule // scmc_divider
`default_nettype wire

// ### test/scmc_clock_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scmc_clock_mode_ctrl_tb;
  import scmc_pkg::*;
  logic clk, nrst, fast_clock_tick, slow_clock_tick, idle_req, timing_gen_halt, stop_req;
  logic stop_release, main_clock_select, fast_osc_enable, slow_osc_enable, irq_req;
  logic stage_seven_source_select, interrupt_master_enable, base_timer_enable;
  logic base_timer_irq_enable, base_timer_src, base_timer_irq_ack, fast_hold, arm;
  logic [3:0] instr_cycles;
  logic [31:0] rnd;
  logic [7:0] cnt;
  logic [7:0] exp_q[$];
  scmc_mode_t mode;
  logic fast_osc_run, slow_osc_run, slow_pins_as_port, core_clk_en, periph_clk_en;
  logic base_timer_clk_en, instr_done, wake_take_irq, wake_resume_next, base_timer_interrupt;
  logic base_timer_irq_service, divider_pulse_out;
  logic [1:0] mc_state;
  logic [DIV_STAGES-1:0] div_value;
  int errors, checked, cycles;

  scmc_clock_mode_ctrl dut_u (.clk(clk), .nrst(nrst), .fast_clock_tick(fast_clock_tick),
    .slow_clock_tick(slow_clock_tick), .idle_req(idle_req), .timing_gen_halt(timing_gen_halt),
    .stop_req(stop_req), .stop_release(stop_release), .main_clock_select(main_clock_select),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
    .stage_seven_source_select(stage_seven_source_select), .irq_req(irq_req),
    .interrupt_master_enable(interrupt_master_enable), .base_timer_enable(base_timer_enable),
    .base_timer_irq_enable(base_timer_irq_enable), .base_timer_src(base_timer_src),
    .base_timer_irq_ack(base_timer_irq_ack), .instr_cycles(instr_cycles), .mode(mode),
    .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run),
    .slow_pins_as_port(slow_pins_as_port), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .base_timer_clk_en(base_timer_clk_en), .mc_state(mc_state),
    .instr_done(instr_done), .wake_take_irq(wake_take_irq), .wake_resume_next(wake_resume_next),
    .base_timer_interrupt(base_timer_interrupt),
    .base_timer_irq_service(base_timer_irq_service), .divider_pulse_out(divider_pulse_out),
    .div_value(div_value));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic cmp(input logic [7:0] got);
    logic [7:0] e;
    e = (exp_q.size() == 0) ? 8'hFF : exp_q.pop_front();
    chk(got, e, "queued result");
  endtask

  task automatic count_en(input int n, output int nc, output int np, output int nb);
    nc = 0;
    np = 0;
    nb = 0;
    repeat (n) begin
      @(posedge clk);
      nc += (core_clk_en === 1'b1);
      np += (periph_clk_en === 1'b1);
      nb += (base_timer_clk_en === 1'b1);
    end
  endtask

  task automatic wait_mode(input scmc_mode_t m, input int n);
    repeat (n) begin
      @(posedge clk);
      if (mode === m) break;
    end
  endtask

  task automatic wait_done;
    repeat (400) begin
      @(posedge clk);
      if (instr_done === 1'b1) break;
    end
  endtask

  // second full instruction after the change is the one measured
  task automatic meas(input logic [3:0] v, input logic [7:0] e);
    @(posedge clk);
    instr_cycles <= v;
    wait_done();
    wait_done();
    exp_q.push_back(e);
    #1 arm = 1'b1;
    wait_done();
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // random basic clock ticks; slow ticks sparser than fast ones
  always @(posedge clk) begin
    rnd <= lfsr_next(rnd);
    fast_clock_tick <= fast_hold | rnd[0];
    slow_clock_tick <= rnd[2] & rnd[5];
  end

  // watcher: pairs each result pulse with the oldest note
  always @(posedge clk) begin
    if (wake_take_irq === 1'b1) cmp(8'h01);
    if (wake_resume_next === 1'b1) cmp(8'h02);
    if (instr_done === 1'b1) begin
      if (arm) cmp(cnt);
      arm = 1'b0;
      cnt = {7'h00, core_clk_en};
    end else begin
      cnt = cnt + {7'h00, core_clk_en};
    end
  end

  // hang guard, sized for the long warm-up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 99000) begin
      errors++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    logic [3:0] v, e;
    logic [3:0] tab [4];
    logic [5:0] d;
    int nc, np, nb;
    {nrst, idle_req, timing_gen_halt, stop_req, stop_release, main_clock_select} = 6'h00;
    {slow_osc_enable, irq_req, interrupt_master_enable, base_timer_enable} = 4'h0;
    {base_timer_irq_enable, base_timer_src, base_timer_irq_ack, fast_hold, arm} = 5'h00;
    stage_seven_source_select = 1'b0; // never set in single-clock use
    fast_osc_enable = 1'b1;
    fast_clock_tick = 1'b0;
    slow_clock_tick = 1'b0;
    instr_cycles = 4'h1;
    rnd = 32'h1787;
    cnt = 8'h00;
    tab = '{4'h0, 4'h1, 4'hA, 4'hB};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(mode, MODE_SINGLE_RUN, "reset mode");
    chk(slow_pins_as_port, 1'b1, "port pins");
    chk(slow_osc_run, 1'b0, "slow osc off");
    chk(div_value, 0, "divider clear");
    chk({mc_state, divider_pulse_out}, {MC_STATE_RST, 1'b0}, "state and pulse");
    // instruction lengths, clamped ends included
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? rnd[3:0] : tab[i];
      e = (v == 4'h0) ? 4'h1 : ((v > 4'hA) ? 4'hA : v);
      meas(v, {2'b00, e, 2'b00});
    end
    // idle, woken by a one-cycle request, master enable on then off
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      interrupt_master_enable <= (i == 0);
      idle_req <= 1'b1;
      @(posedge clk);
      idle_req <= 1'b0;
      #1 chk(mode, MODE_SINGLE_IDLE, "idle entry");
      count_en(20, nc, np, nb);
      chk(nc, 0, "core halted");
      chk(np > 0, 1, "periph runs");
      exp_q.push_back((i == 0) ? 8'h01 : 8'h02);
      @(posedge clk);
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0; // short pulse must not be lost
      wait_mode(MODE_SINGLE_RUN, 4);
      #1 chk(mode, MODE_SINGLE_RUN, "idle wake");
    end
    // idle and request together: the held request wakes it a cycle later
    @(posedge clk);
    exp_q.push_back(8'h02);
    {idle_req, irq_req} <= 2'h3;
    @(posedge clk);
    {idle_req, irq_req} <= 2'h0;
    #1 chk(mode, MODE_SINGLE_IDLE, "idle with request");
    wait_mode(MODE_SINGLE_RUN, 4);
    #1 chk(mode, MODE_SINGLE_RUN, "held wake");
    // timing halt, base timer enabled then disabled
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      base_timer_enable <= (i == 0);
      base_timer_src <= 1'b1;
      timing_gen_halt <= 1'b1;
      @(posedge clk);
      timing_gen_halt <= 1'b0;
      #1 chk(mode, MODE_TIMER_IDLE, "halt entry");
      count_en(20, nc, np, nb);
      chk(nc + np, 0, "core and periph gated");
      chk(nb > 0, 1, "base timer clocked");
      @(posedge clk);
      base_timer_src <= 1'b0;
      wait_mode(MODE_SINGLE_RUN, 4);
      #1 chk(mode, MODE_SINGLE_RUN, "halt wake");
      repeat (2) @(posedge clk);
      #1 chk(base_timer_interrupt, (i == 0), "timer latch");
      if (i == 0) begin
        @(posedge clk);
        interrupt_master_enable <= 1'b1;
        base_timer_irq_enable <= 1'b1;
        @(posedge clk);
        #1 chk(base_timer_irq_service, 1'b1, "service on");
        @(posedge clk);
        base_timer_irq_enable <= 1'b0;
        base_timer_irq_ack <= 1'b1;
        @(posedge clk);
        base_timer_irq_ack <= 1'b0;
        #1 chk(base_timer_irq_service, 1'b0, "service off");
        @(posedge clk);
        #1 chk(base_timer_interrupt, 1'b0, "ack clears");
      end
    end
    // stop and warm-up; steady fast ticks keep the wait short
    @(posedge clk);
    fast_hold <= 1'b1;
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    #1 chk(mode, MODE_STOP, "stop entry");
    chk(div_value, 0, "clear on stop");
    repeat (3) @(posedge clk);
    stop_release <= 1'b1;
    @(posedge clk);
    stop_release <= 1'b0;
    #1 chk(mode, MODE_WARMUP, "warm-up");
    chk(div_value, 0, "clear on release");
    wait_mode(MODE_SINGLE_RUN, 80000);
    #1 chk(mode, MODE_SINGLE_RUN, "warm-up end");
    // dual clock round trip
    @(posedge clk);
    fast_hold <= 1'b0;
    slow_osc_enable <= 1'b1; // slow oscillator switched on early
    @(posedge clk);
    #1 chk(mode, MODE_DUAL_FAST, "dual fast");
    chk({slow_pins_as_port, slow_osc_run}, 2'h1, "pins and osc");
    @(posedge clk);
    stage_seven_source_select <= 1'b1; // dual mode, slow clock running
    repeat (20) @(posedge clk);
    main_clock_select <= 1'b1;
    @(posedge clk);
    #1 chk(mode, MODE_DUAL_SLOW, "dual slow");
    @(posedge clk);
    fast_osc_enable <= 1'b0;
    @(posedge clk);
    #1 chk(mode, MODE_SLOW_ONLY, "slow only");
    chk(fast_osc_run, 1'b0, "fast osc off");
    d = div_value[5:0];
    repeat (30) @(posedge clk);
    #1 chk(div_value[5:0], d, "low stages held");
    meas(4'h2, 8'h08);
    @(posedge clk);
    fast_osc_enable <= 1'b1;
    stage_seven_source_select <= 1'b0; // clear before single-clock mode
    @(posedge clk);
    main_clock_select <= 1'b0;
    @(posedge clk);
    slow_osc_enable <= 1'b0;
    @(posedge clk);
    #1 chk(mode, MODE_SINGLE_RUN, "back to single");
    repeat (4) @(posedge clk);
    chk(exp_q.size(), 0, "all results seen");
    finish_test();
  end
endmodule // scmc_clock_mode_ctrl_tb
`default_nettype wire
